//--- include/awss_pkg.sv
// Package of offsets, field layout and reset values for the wait-count bank.
package awss_pkg;

  // --------------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------------
  localparam int AWSS_ADDR_W = 4;   // Register port address width.
  localparam int AWSS_DATA_W = 16;  // Register width.
  localparam int AWSS_CNT_W  = 3;   // Width of one area's wait count.
  localparam int AWSS_AREAS  = 8;   // Number of external address areas.
  localparam int AWSS_SLOTS  = 4;   // Areas held by one wait register.

  // --------------------------------------------------------------------------
  // Register offsets on the plain register port
  // --------------------------------------------------------------------------
  localparam logic [AWSS_ADDR_W-1:0] AWSS_OFS_UPPER = 4'h0;
  localparam logic [AWSS_ADDR_W-1:0] AWSS_OFS_LOWER = 4'h2;
  localparam logic [AWSS_ADDR_W-1:0] AWSS_OFS_ASTC  = 4'h4;

  // --------------------------------------------------------------------------
  // Field layout
  // --------------------------------------------------------------------------
  // Area slot s of a wait register sits at bits 4*s+2 down to 4*s.
  localparam int AWSS_FLD_STRIDE = 4;
  // Three-state bit of area n sits at bit AWSS_AST_LSB + n.
  localparam int AWSS_AST_LSB = 8;
  // Writable bits; everything else is reserved and reads as zero.
  localparam logic [AWSS_DATA_W-1:0] AWSS_WAIT_MASK = 16'h7777;
  localparam logic [AWSS_DATA_W-1:0] AWSS_ASTC_MASK = 16'hff00;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [AWSS_DATA_W-1:0] AWSS_RST_WAIT = 16'h7777;
  localparam logic [AWSS_DATA_W-1:0] AWSS_RST_ASTC = 16'hff00;

  // --------------------------------------------------------------------------
  // Wait counter states
  // --------------------------------------------------------------------------
  typedef enum logic {
    AWSS_IDLE = 1'b0,
    AWSS_WAIT = 1'b1
  } awss_wait_state_t;

endpackage

//--- design/awss_wait_counter.sv
// Wait-cycle counter that stretches one external access by a latched count.
`timescale 1ns/10ps
`default_nettype none

module awss_wait_counter
  import awss_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             arst_n,
  input  wire logic                             ce,
  input  wire logic                             load,
  input  wire logic [awss_pkg::AWSS_CNT_W-1:0]  load_cnt,
  output logic                                  wait_insert,
  output logic      [awss_pkg::AWSS_CNT_W-1:0]  cnt
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  awss_wait_state_t              state_r;  // Idle or inserting waits.
  awss_wait_state_t              state_nxt;
  logic [AWSS_CNT_W-1:0]         cnt_r;    // Wait cycles still to insert.
  logic [AWSS_CNT_W-1:0]         cnt_nxt;

  // Next-state logic; a load always wins so a new access restarts cleanly.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (load) begin
      cnt_nxt   = load_cnt;
      state_nxt = (load_cnt != '0) ? AWSS_WAIT : AWSS_IDLE;
    end else begin
      case (state_r)
        AWSS_IDLE: begin
          state_nxt = AWSS_IDLE;
        end
        AWSS_WAIT: begin
          // One wait cycle is spent in each enabled clock.
          cnt_nxt   = cnt_r - 3'h1;
          state_nxt = (cnt_r == 3'h1) ? AWSS_IDLE : AWSS_WAIT;
        end
        default: begin
          state_nxt = AWSS_IDLE;
        end
      endcase
    end
  end

  // The count is held here, so later register writes cannot disturb it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= AWSS_IDLE;
      cnt_r   <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign wait_insert = (state_r == AWSS_WAIT);
  assign cnt         = cnt_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_load_count:
    assert property (@(posedge clk) disable iff (!arst_n)
      (load && ce) |=> (cnt == $past(load_cnt)) &&
                       (wait_insert == ($past(load_cnt) != 3'h0)))
    else $error("Loaded wait count not taken as an unsigned count.");

  a_count_down:
    assert property (@(posedge clk) disable iff (!arst_n)
      (wait_insert && ce && !load) |=>
        (cnt == $past(cnt) - 3'h1) &&
        (wait_insert == ($past(cnt) != 3'h1)))
    else $error("Wait count did not step down by one.");

  c_seven_waits:
    cover property (@(posedge clk) disable iff (!arst_n)
      (load && ce && load_cnt == 3'h7) ##1 wait_insert[*7] ##1 !wait_insert);

endmodule

`default_nettype wire

//--- design/awss_top.sv
// Wait-count register bank of the external bus controller.
//
// Overview of operation
// - Two registers hold eight per-area wait counts.
// - Field is unsigned count, zero to seven.
// - Count applies only when area is three-state.
// - Upper register: area 7 14:12, 6 10:8.
// - Upper register: area 5 6:4, 4 2:0.
// - Lower register holds areas 3 to 0 likewise.
// - Bits 15, 11, 7, 3 read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none

module awss_top
  import awss_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic                              ce,
  input  wire logic [awss_pkg::AWSS_ADDR_W-1:0]  reg_addr,
  input  wire logic [awss_pkg::AWSS_DATA_W-1:0]  reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [awss_pkg::AWSS_DATA_W-1:0]  reg_rdata,
  input  wire logic                              acc_start,
  input  wire logic [2:0]                        acc_area,
  output logic                                   wait_insert,
  output logic      [awss_pkg::AWSS_CNT_W-1:0]   wait_count
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------

  // Picks the wait field of one slot out of a wait register.
  function automatic logic [AWSS_CNT_W-1:0] field_of(
    input logic [AWSS_DATA_W-1:0] word,
    input int                     slot
  );
    field_of = word[slot*AWSS_FLD_STRIDE +: AWSS_CNT_W];
  endfunction

  // Address decode, used by both the write and the read path.
  function automatic logic hit(
    input logic [AWSS_ADDR_W-1:0] addr,
    input logic [AWSS_ADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [AWSS_DATA_W-1:0] upper_area_wait_counts_r;  // Areas 7 to 4.
  logic [AWSS_DATA_W-1:0] lower_area_wait_counts_r;  // Areas 3 to 0.
  logic [AWSS_DATA_W-1:0] access_state_config_r;     // Three-state bits.
  logic [AWSS_DATA_W-1:0] reg_rdata_r;               // Read answer.
  logic [AWSS_DATA_W-1:0] reg_rdata_nxt;

  // Upper wait register; the mask keeps reserved bits at zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upper_area_wait_counts_r <= AWSS_RST_WAIT;
    end else if (ce && reg_wr && hit(reg_addr, AWSS_OFS_UPPER)) begin
      upper_area_wait_counts_r <= reg_wdata & AWSS_WAIT_MASK;
    end
  end

  // Lower wait register, laid out like the upper one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lower_area_wait_counts_r <= AWSS_RST_WAIT;
    end else if (ce && reg_wr && hit(reg_addr, AWSS_OFS_LOWER)) begin
      lower_area_wait_counts_r <= reg_wdata & AWSS_WAIT_MASK;
    end
  end

  // Three-state selection per area; its low byte is read-only zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      access_state_config_r <= AWSS_RST_ASTC;
    end else if (ce && reg_wr && hit(reg_addr, AWSS_OFS_ASTC)) begin
      access_state_config_r <= reg_wdata & AWSS_ASTC_MASK;
    end
  end

  // Read multiplexer; unmapped addresses answer zero.
  always_comb begin
    reg_rdata_nxt = '0;
    if (reg_rd) begin
      if (hit(reg_addr, AWSS_OFS_UPPER)) begin
        reg_rdata_nxt = upper_area_wait_counts_r;
      end else if (hit(reg_addr, AWSS_OFS_LOWER)) begin
        reg_rdata_nxt = lower_area_wait_counts_r;
      end else if (hit(reg_addr, AWSS_OFS_ASTC)) begin
        reg_rdata_nxt = access_state_config_r;
      end else begin
        reg_rdata_nxt = '0;
      end
    end
  end

  // Read data stands from the enabled edge after the strobe and drops to zero at
  // the next enabled edge; while ce is low the register holds its older answer.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_r <= '0;
    end else if (ce) begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;

  // --------------------------------------------------------------------------
  // Effective wait count per area
  // --------------------------------------------------------------------------
  logic [AWSS_CNT_W-1:0] eff_cnt [AWSS_AREAS];  // Count the area will use.

  // Two-state areas get zero waits whatever their field holds.
  for (genvar n = 0; n < AWSS_AREAS; n++) begin : g_area
    localparam int SLOT = n % AWSS_SLOTS;
    logic [AWSS_CNT_W-1:0] raw;  // Field as programmed.
    if (n >= AWSS_SLOTS) begin : g_up
      assign raw = field_of(upper_area_wait_counts_r, SLOT);
    end else begin : g_lo
      assign raw = field_of(lower_area_wait_counts_r, SLOT);
    end
    assign eff_cnt[n] = access_state_config_r[AWSS_AST_LSB + n] ?
                        raw : '0;
  end

  // --------------------------------------------------------------------------
  // Wait insertion for the running access
  // --------------------------------------------------------------------------
  logic [AWSS_CNT_W-1:0] start_cnt;  // Count selected by the access area.

  assign start_cnt = eff_cnt[acc_area];

  // The count is sampled once at the access start and held by the counter,
  // trading reprogramming latency for a stable cycle length.
  awss_wait_counter u_cnt (
    .clk         (clk),
    .arst_n      (arst_n),
    .ce          (ce),
    .load        (acc_start),
    .load_cnt    (start_cnt),
    .wait_insert (wait_insert),
    .cnt         (wait_count)
  );

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_upper_write:
    assert property (@(posedge clk) disable iff (!arst_n)
      (ce && reg_wr && reg_addr == AWSS_OFS_UPPER) |=>
        upper_area_wait_counts_r == ($past(reg_wdata) & AWSS_WAIT_MASK))
    else $error("Upper wait register did not take the write.");

  a_read_back:
    assert property (@(posedge clk) disable iff (!arst_n)
      (ce && reg_rd && reg_addr == AWSS_OFS_LOWER) |=>
        reg_rdata == $past(lower_area_wait_counts_r))
    else $error("Lower wait register read back wrong.");

  // The stored wait registers must never hold a reserved bit; the read
  // answer may show bits 15 and 11 only when it came from the config
  // register, or while a frozen clock enable holds an older answer.
  a_resvd_zero:
    assert property (@(posedge clk) disable iff (!arst_n)
      (((upper_area_wait_counts_r | lower_area_wait_counts_r) & 16'h8888)
        == 16'h0000) &&
      (((reg_rdata & 16'h8888) == 16'h0000) || !$past(ce) ||
       ($past(reg_rd) && $past(reg_addr) == AWSS_OFS_ASTC)))
    else $error("Reserved wait bit is set.");

  a_area7_field:
    assert property (@(posedge clk) disable iff (!arst_n)
      (ce && acc_start && acc_area == 3'h7 && access_state_config_r[15])
        |=> wait_count == $past(upper_area_wait_counts_r[14:12]))
    else $error("Area 7 wait count taken from wrong bits.");

  a_area4_field:
    assert property (@(posedge clk) disable iff (!arst_n)
      (ce && acc_start && acc_area == 3'h4 && access_state_config_r[12])
        |=> wait_count == $past(upper_area_wait_counts_r[2:0]))
    else $error("Area 4 wait count taken from wrong bits.");

  a_area2_field:
    assert property (@(posedge clk) disable iff (!arst_n)
      (ce && acc_start && acc_area == 3'h2 && access_state_config_r[10])
        |=> wait_count == $past(lower_area_wait_counts_r[10:8]))
    else $error("Area 2 wait count taken from wrong bits.");

  a_two_state_nowait:
    assert property (@(posedge clk) disable iff (!arst_n)
      (ce && acc_start && !access_state_config_r[8 + acc_area])
        |=> !wait_insert && wait_count == 3'h0)
    else $error("Two-state area received wait cycles.");

  a_latch_hold:
    assert property (@(posedge clk) disable iff (!arst_n)
      (ce && wait_insert && reg_wr && !acc_start) |=>
        wait_count == $past(wait_count) - 3'h1)
    else $error("Register write disturbed a running access.");

  c_upper_write:
    cover property (@(posedge clk) disable iff (!arst_n)
      ce && reg_wr && reg_addr == AWSS_OFS_UPPER);

  c_wait_access:
    cover property (@(posedge clk) disable iff (!arst_n)
      ce && acc_start ##1 wait_insert[*3]);

  c_write_then_read:
    cover property (@(posedge clk) disable iff (!arst_n)
      (ce && reg_wr && reg_addr == AWSS_OFS_LOWER) ##1
      (ce && reg_rd && reg_addr == AWSS_OFS_LOWER));

endmodule

`default_nettype wire

//--- testbench/awss_ext_model.sv
// Behavioural model of the external side that starts area accesses.
`timescale 1ns/10ps
`default_nettype none

module awss_ext_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       go,
  input  wire logic [2:0] go_area,
  input  wire logic       wait_insert,
  output logic            acc_start,
  output logic      [2:0] acc_area,
  output logic      [3:0] waits_seen
);
  // --------------------------------------------------------------------------
  // Access launch
  // --------------------------------------------------------------------------
  // The area lines toggle when no start is shown, so nothing may lean on them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_start <= 1'b0;
      acc_area  <= 3'h0;
    end else begin
      acc_start <= go;
      acc_area  <= go ? go_area : ~acc_area;
    end
  end

  // --------------------------------------------------------------------------
  // Wait measurement
  // --------------------------------------------------------------------------
  // Counts stretched cycles of the latest access; four bits show overshoot.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waits_seen <= 4'h0;
    end else if (acc_start) begin
      waits_seen <= 4'h0;
    end else if (wait_insert) begin
      waits_seen <= waits_seen + 4'h1;
    end
  end
endmodule

`default_nettype wire

//--- testbench/area_wait_state_select_tb.sv
// Self-checking testbench of the per-area wait-count register bank.
`timescale 1ns/10ps
`default_nettype none

module area_wait_state_select_tb;
  import awss_pkg::*;
  localparam int MAX_CYC = 20000;  // Generous; the run needs about 3200.
  logic        clk, arst_n, ce, reg_wr, reg_rd, go;
  logic        acc_start, wait_insert;
  logic [3:0]  reg_addr, waits_seen;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0]  go_area, acc_area, wait_count;
  logic [15:0] sh_up, sh_lo, sh_cfg;  // Expected register contents.
  int          n_errors, samples_checked, cyc;

  awss_top i_awss_top (.clk(clk), .arst_n(arst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_start(acc_start),
    .acc_area(acc_area), .wait_insert(wait_insert),
    .wait_count(wait_count));
  awss_ext_model i_awss_ext_model (.clk(clk), .arst_n(arst_n), .go(go),
    .go_area(go_area), .wait_insert(wait_insert), .acc_start(acc_start),
    .acc_area(acc_area), .waits_seen(waits_seen));

  // --------------------------------------------------------------------------
  // Clock, timeout and verdict
  // --------------------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      n_errors++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------------------
  // Expectation functions
  // --------------------------------------------------------------------------
  function automatic logic [15:0] exp_reg(input logic [3:0] a);
    case (a)
      AWSS_OFS_UPPER: return sh_up;
      AWSS_OFS_LOWER: return sh_lo;
      AWSS_OFS_ASTC:  return sh_cfg;
      default:        return 16'h0000;
    endcase
  endfunction

  // A field counts only while its area is three-state.
  function automatic logic [2:0] exp_wait(input logic [2:0] area);
    logic [2:0] f;
    f = area[2] ? sh_up[4*area[1:0] +: 3] : sh_lo[4*area[1:0] +: 3];
    return sh_cfg[8+area] ? f : 3'h0;
  endfunction

  // Gives each slot a different code so a swapped field shows up.
  function automatic logic [15:0] pack(input int k, input int hi);
    logic [15:0] w;
    w = 16'h0000;
    for (int s = 0; s < 4; s++) begin
      w[4*s +: 3] = 3'(k + s + 4*hi);
    end
    return w;
  endfunction

  // --------------------------------------------------------------------------
  // Bus and access tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Reserved bits never take the written value.
    if (a == AWSS_OFS_UPPER) sh_up = d & 16'h7777;
    if (a == AWSS_OFS_LOWER) sh_lo = d & 16'h7777;
    if (a == AWSS_OFS_ASTC) sh_cfg = d & 16'hff00;
  endtask

  task automatic rd_chk(input logic [3:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp_reg(a));
    @(posedge clk);
    #1 chk("reg_rdata_idle", reg_rdata, 16'h0000);
  endtask

  // With mid set, the area's register is rewritten during the wait.
  task automatic run_acc(input logic [2:0] area, input bit mid);
    logic [2:0] e;
    e = exp_wait(area);
    @(posedge clk);
    go      <= 1'b1;
    go_area <= area;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1 chk("wait_count", {13'h0, wait_count}, {13'h0, e});
    if (mid) begin
      wr_reg(area[2] ? AWSS_OFS_UPPER : AWSS_OFS_LOWER, ~exp_reg(
             area[2] ? AWSS_OFS_UPPER : AWSS_OFS_LOWER));
    end
    repeat (mid ? 6 : 8) @(posedge clk);
    #1 chk("waits_seen", {12'h0, waits_seen}, {13'h0, e});
  endtask

  // Clock enable low for four edges freezes a running wait; the partner
  // still counts those edges, so they add to the waits it sees.
  task automatic run_frozen(input logic [2:0] area);
    logic [2:0]  e;
    logic [15:0] x;
    e = exp_wait(area);
    x = {13'h0, e} + ((e != 3'h0) ? 16'h0004 : 16'h0000);
    @(posedge clk);
    go      <= 1'b1;
    go_area <= area;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    ce <= 1'b0;
    #1 chk("frozen_load", {13'h0, wait_count}, {13'h0, e});
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    #1 chk("frozen_count", {13'h0, wait_count}, {13'h0, e});
    repeat (8) @(posedge clk);
    #1 chk("frozen_waits", {12'h0, waits_seen}, x);
  endtask

  // A second start one cycle after the first reloads the counter, so only
  // the second access's count may be seen.
  task automatic run_two(input logic [2:0] a1, input logic [2:0] a2);
    logic [2:0] e;
    e = exp_wait(a2);
    @(posedge clk);
    go      <= 1'b1;
    go_area <= a1;
    @(posedge clk);
    go_area <= a2;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1 chk("reload_count", {13'h0, wait_count}, {13'h0, e});
    repeat (8) @(posedge clk);
    #1 chk("reload_waits", {12'h0, waits_seen}, {13'h0, e});
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {arst_n, reg_wr, reg_rd, go} = 4'h0;
    ce        = 1'b1;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    go_area   = 3'h0;
    sh_up     = 16'h7777;
    sh_lo     = 16'h7777;
    sh_cfg    = 16'hff00;
    void'($urandom(42162));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, and the unmapped offset reads zero.
    for (int a = 0; a < 8; a += 2) rd_chk(4'(a));
    // Writes to reserved bits are dropped.
    wr_reg(AWSS_OFS_UPPER, 16'hffff);
    rd_chk(AWSS_OFS_UPPER);
    wr_reg(AWSS_OFS_LOWER, 16'h8888);
    rd_chk(AWSS_OFS_LOWER);
    // Every code on every area, fields placed per slot.
    for (int k = 0; k < 8; k++) begin
      wr_reg(AWSS_OFS_UPPER, pack(k, 1));
      wr_reg(AWSS_OFS_LOWER, pack(k, 0));
      rd_chk(AWSS_OFS_UPPER);
      rd_chk(AWSS_OFS_LOWER);
      for (int a = 0; a < 8; a++) run_acc(3'(a), 1'b0);
    end
    // Two-state areas get no waits at all.
    wr_reg(AWSS_OFS_ASTC, 16'h00ff);
    for (int a = 0; a < 8; a++) run_acc(3'(a), 1'b0);
    wr_reg(AWSS_OFS_ASTC, 16'hff00);
    run_acc(3'h7, 1'b1);
    // Hand-picked: area 7 waits five, area 4 none; freeze, then reload.
    wr_reg(AWSS_OFS_UPPER, 16'h5000);
    run_frozen(3'h7);
    run_two(3'h7, 3'h4);
    run_two(3'h4, 3'h7);
    // Random traffic across all offsets, with mid-wait rewrites.
    for (int i = 0; i < 80; i++) begin
      reg_wdata <= reg_wdata;
      wr_reg(4'(2*$urandom_range(3, 0)), 16'($urandom));
      rd_chk(4'(2*$urandom_range(3, 0)));
      run_acc(3'($urandom_range(7, 0)), 1'($urandom_range(1, 0)));
      run_two(3'($urandom_range(7, 0)), 3'($urandom_range(7, 0)));
    end
    // A second reset in mid-run restores every reset value.
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    sh_up  = 16'h7777;
    sh_lo  = 16'h7777;
    sh_cfg = 16'hff00;
    for (int a = 0; a < 8; a += 2) rd_chk(4'(a));
    end_of_test();
  end
endmodule

`default_nettype wire
